// ==== hw/sap_pkg.sv ====
// Constants and types shared by the address protection block.
package sap_pkg;

  // ****************************************************************
  // Address map
  // ****************************************************************
  localparam logic [31:0] ROM_BASE      = 32'h0000_0000;
  localparam logic [31:0] ROM_LAST      = 32'h0001_FFFF;
  localparam logic [31:0] SRAM_APP_BASE = 32'h0800_0000;
  localparam logic [31:0] SRAM_APP_LAST = 32'h0802_BFFF;
  localparam logic [31:0] SRAM_SYS_BASE = 32'h0802_C000;
  localparam logic [31:0] SRAM_SYS_LAST = 32'h0804_7FFF;
  localparam logic [31:0] APP_FL_BASE   = 32'h1000_0000;
  localparam logic [31:0] APP_FL_LAST   = 32'h100C_FFFF;
  localparam logic [31:0] SEC_FL_BASE   = 32'h100D_0000;
  localparam logic [31:0] SEC_FL_LAST   = 32'h100F_FFFF;
  localparam logic [31:0] AUX_FL_BASE   = 32'h1400_0000;
  localparam logic [31:0] AUX_FL_LAST   = 32'h1400_7FFF;
  localparam logic [31:0] SUP_FL_BASE   = 32'h1600_0000;
  localparam logic [31:0] SUP_FL_LAST   = 32'h1600_7FFF;
  localparam logic [31:0] NOMEM_BASE    = 32'h2000_0000;
  localparam logic [31:0] NOMEM_LAST    = 32'h3FFF_FFFF;
  localparam logic [31:0] PERI_BASE     = 32'h4000_0000;
  localparam logic [31:0] PERI_LAST     = 32'h5FFF_FFFF;
  localparam logic [31:0] EXT_BASE      = 32'h6000_0000;
  localparam logic [31:0] EXT_LAST      = 32'h9FFF_FFFF;
  localparam logic [31:0] PPB_BASE      = 32'hE000_0000;
  localparam logic [31:0] PPB_LAST      = 32'hE00F_FFFF;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int FLASH_LINE_LSB = 4;   // 128-bit flash read word.
  localparam int FLASH_ROW_LSB  = 9;   // 512-byte program row.
  localparam int CACHE_SET_W    = 7;   // 8 KB / 4 ways / 16-byte lines.
  localparam int CACHE_WAYS     = 4;
  localparam int SRAM_BLK_LSB   = 15;  // 32-KB power blocks.
  localparam int SRAM_BLOCKS    = 9;
  localparam int FUSE_BITS      = 1024;
  localparam int CONTEXTS       = 8;
  localparam int MASTERS        = 8;
  localparam logic [2:0] BOOT_CTX = 3'h0;
  localparam logic [2:0] APP_CTX  = 3'h6;

  // ****************************************************************
  // Bus masters and permission field positions
  // ****************************************************************
  localparam logic [2:0] MST_MAIN   = 3'h0;
  localparam logic [2:0] MST_SECOND = 3'h1;
  localparam logic [2:0] MST_DEBUG  = 3'h4;
  localparam int PERM_R = 0;
  localparam int PERM_W = 1;
  localparam int PERM_X = 2;
  localparam int PERM_PRIV_LSB = 3;
  localparam logic [5:0] PERM_RESET = 6'h3F;

  typedef enum logic [3:0] {
    RG_NONE = 4'h0, RG_ROM = 4'h1, RG_SRAM_APP = 4'h2, RG_SRAM_SYS = 4'h3,
    RG_APP_FL = 4'h4, RG_SEC_FL = 4'h5, RG_AUX_FL = 4'h6, RG_SUP_FL = 4'h7,
    RG_PERI = 4'h8, RG_EXT = 4'h9, RG_PPB = 4'hA
  } region_t;

  typedef enum logic [1:0] {
    PM_LP = 2'h0, PM_ULP = 2'h1, PM_DEEPSLEEP = 2'h2, PM_HIBERNATE = 2'h3
  } power_t;

endpackage : sap_pkg

// ==== hw/addr_decode_if.sv ====
// Interface between the protection core and its address decoder.
`timescale 1ns/1ps
interface addr_decode_if;
  logic [31:0]          addr;
  sap_pkg::region_t     region;
  logic                 fetchOk;
  logic [3:0]           sramBlock;

  modport core (output addr, input region, fetchOk, sramBlock);
  modport decoder (input addr, output region, fetchOk, sramBlock);
endinterface : addr_decode_if

// ==== hw/region_decoder.sv ====
// Fixed address map decoder.
`timescale 1ns/1ps
module region_decoder (
  addr_decode_if.decoder dec
);

  function automatic logic inRange(input logic [31:0] a, input logic [31:0] lo,
                                   input logic [31:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction : inRange

  wire hitRom   = inRange(dec.addr, sap_pkg::ROM_BASE, sap_pkg::ROM_LAST);
  wire hitSramA = inRange(dec.addr, sap_pkg::SRAM_APP_BASE, sap_pkg::SRAM_APP_LAST);
  wire hitSramS = inRange(dec.addr, sap_pkg::SRAM_SYS_BASE, sap_pkg::SRAM_SYS_LAST);
  wire hitAppFl = inRange(dec.addr, sap_pkg::APP_FL_BASE, sap_pkg::APP_FL_LAST);
  wire hitSecFl = inRange(dec.addr, sap_pkg::SEC_FL_BASE, sap_pkg::SEC_FL_LAST);
  wire hitAuxFl = inRange(dec.addr, sap_pkg::AUX_FL_BASE, sap_pkg::AUX_FL_LAST);
  wire hitSupFl = inRange(dec.addr, sap_pkg::SUP_FL_BASE, sap_pkg::SUP_FL_LAST);
  wire hitNoMem = inRange(dec.addr, sap_pkg::NOMEM_BASE, sap_pkg::NOMEM_LAST);
  wire hitPeri  = inRange(dec.addr, sap_pkg::PERI_BASE, sap_pkg::PERI_LAST);
  wire hitExt   = inRange(dec.addr, sap_pkg::EXT_BASE, sap_pkg::EXT_LAST);
  wire hitPpb   = inRange(dec.addr, sap_pkg::PPB_BASE, sap_pkg::PPB_LAST);

  // The empty data window decodes to nothing so it is always refused.
  assign dec.region = hitNoMem ? sap_pkg::RG_NONE :
                      hitRom   ? sap_pkg::RG_ROM :
                      hitSramA ? sap_pkg::RG_SRAM_APP :
                      hitSramS ? sap_pkg::RG_SRAM_SYS :
                      hitAppFl ? sap_pkg::RG_APP_FL :
                      hitSecFl ? sap_pkg::RG_SEC_FL :
                      hitAuxFl ? sap_pkg::RG_AUX_FL :
                      hitSupFl ? sap_pkg::RG_SUP_FL :
                      hitPeri  ? sap_pkg::RG_PERI :
                      hitExt   ? sap_pkg::RG_EXT :
                      hitPpb   ? sap_pkg::RG_PPB : sap_pkg::RG_NONE;

  // Peripheral and core-private space never supplies instructions.
  assign dec.fetchOk = !(hitPeri || hitPpb);

  wire [31:0] sramOffset = dec.addr - sap_pkg::SRAM_APP_BASE;
  assign dec.sramBlock = sramOffset[sap_pkg::SRAM_BLK_LSB +: 4];

endmodule : region_decoder

// ==== hw/system_address_protection.sv ====
// Access checking, address decoding, flash, fuse and boot control.
`timescale 1ns/1ps

// How it works
// - Check range, direction, fetch, privilege, security, context
// - Eight contexts, boot in context 0, per-master rights
// - Main processor applications run in context 6
// - Default guard setup, locked from user software
// - Flash reads use 128-bit words
// - Flash programming works on 512-byte rows
// - Flash writes refused in ultra-low-power mode
// - Secure lifecycle locks supervisory flash sector
// - Two 8 KB 4-way caches, one per processor
// - SRAM power and retention per 32-KB block
// - Supervisory ROM fetch: secondary processor, context 0
// - System-function request raises secondary processor NMI
// - 1024 one-time fuses, only 0 to 1
// - ROM boot runs first after every reset
// - Flash boot after validation; failure gives safe state
// - Peripheral space mapped, instruction fetch refused
// - External serial memory mapped, fetch allowed
// - Standard SRAM window holds no memory
// - Application and secured-code flash decode
// - Auxiliary flash sector decode
// - Supervisory flash sector, secured access only
// - Core-private peripheral window per processor
module system_address_protection #(
  parameter int CONTEXTS    = sap_pkg::CONTEXTS,
  parameter int MASTERS     = sap_pkg::MASTERS,
  parameter int SRAM_BLOCKS = sap_pkg::SRAM_BLOCKS,
  parameter int FUSE_BITS   = sap_pkg::FUSE_BITS
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  // Access request from a bus master
  input  wire logic                   reqValid,
  input  wire logic [31:0]            reqAddr,
  input  wire logic                   reqWrite,
  input  wire logic                   reqFetch,
  input  wire logic                   reqPriv,
  input  wire logic                   reqSecure,
  input  wire logic [2:0]             reqContext,
  input  wire logic [2:0]             reqMaster,
  // Access answer
  output logic                        respValid,
  output logic                        respError,
  output sap_pkg::region_t            respRegion,
  output logic                        respCacheSel,
  output logic [6:0]                  respCacheSet,
  output logic [27:0]                 flashLineAddr,
  output logic [22:0]                 flashRowAddr,
  output logic                        flashRowWrite,
  output logic                        ppbLocal,
  // Fault flag
  output logic                        faultFlag,
  output logic [31:0]                 faultAddr,
  input  wire logic                   faultClear,
  // Guard configuration during ROM boot
  input  wire logic                   cfgValid,
  input  wire logic [2:0]             cfgContext,
  input  wire logic [2:0]             cfgMaster,
  input  wire logic [5:0]             cfgPerm,
  // System state
  input  sap_pkg::power_t             powerMode,
  input  wire logic                   lifecycleSecure,
  input  wire logic [SRAM_BLOCKS-1:0] sramPowerReq,
  input  wire logic [SRAM_BLOCKS-1:0] sramRetainReq,
  output logic [SRAM_BLOCKS-1:0]      sramPowered,
  output logic [SRAM_BLOCKS-1:0]      sramRetained,
  // System function requests
  input  wire logic                   sysCallMain,
  input  wire logic                   sysCallSecond,
  input  wire logic                   sysCallDebug,
  output logic                        nmiSecond,
  // Fuse array
  input  wire logic                   fuseProgValid,
  input  wire logic [9:0]             fuseProgIndex,
  input  wire logic [9:0]             fuseReadIndex,
  output logic                        fuseReadBit,
  // Boot sequence
  input  wire logic                   romBootDone,
  input  wire logic                   flashBootValid,
  input  wire logic                   flashBootDone,
  input  wire logic                   appImageValid,
  output logic [4:0]                  bootPhase,
  output logic                        safeState
);

  // ****************************************************************
  // Boot sequencer
  // ****************************************************************
  typedef enum logic [4:0] {
    BT_RESET = 5'b00001,
    BT_ROM   = 5'b00010,
    BT_FLASH = 5'b00100,
    BT_APP   = 5'b01000,
    BT_SAFE  = 5'b10000
  } boot_t;

  boot_t boot;
  boot_t next_boot;

  always_comb begin
    next_boot = boot;
    case (boot)
      BT_RESET: next_boot = BT_ROM;
      BT_ROM: begin
        if (romBootDone) begin
          next_boot = flashBootValid ? BT_FLASH : BT_SAFE;
        end
      end
      BT_FLASH: begin
        if (flashBootDone) begin
          next_boot = appImageValid ? BT_APP : BT_SAFE;
        end
      end
      BT_APP:  next_boot = BT_APP;
      BT_SAFE: next_boot = BT_SAFE;
      default: next_boot = BT_SAFE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      boot <= BT_RESET;
    end else begin
      boot <= next_boot;
    end
  end

  wire inRomBoot = (boot == BT_ROM);
  wire inAppRun  = (boot == BT_APP);

  // ****************************************************************
  // Guard permission table
  // ****************************************************************
  // Each entry holds user read/write/fetch in the low bits and the
  // privileged copy above. Only ROM boot may rewrite it.
  logic [5:0] perm [CONTEXTS][MASTERS];

  wire cfgAccept = cfgValid && inRomBoot;

  generate
    for (genvar c = 0; c < CONTEXTS; c++) begin : g_ctx
      for (genvar m = 0; m < MASTERS; m++) begin : g_mst
        wire hitCfg = cfgAccept && (cfgContext == 3'(c)) && (cfgMaster == 3'(m));
        always_ff @(posedge clk or negedge arst_n) begin
          if (!arst_n) begin
            perm[c][m] <= sap_pkg::PERM_RESET;
          end else if (hitCfg) begin
            perm[c][m] <= cfgPerm;
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Address decode and access checks
  // ****************************************************************
  addr_decode_if dec ();

  assign dec.addr = reqAddr;

  region_decoder u_decoder (
    .dec (dec.decoder)
  );

  wire [5:0] entry  = perm[reqContext][reqMaster];
  wire [2:0] rights = reqPriv ? entry[sap_pkg::PERM_PRIV_LSB +: 3] : entry[2:0];

  wire permOk = reqFetch ? rights[sap_pkg::PERM_X] :
                reqWrite ? rights[sap_pkg::PERM_W] : rights[sap_pkg::PERM_R];

  wire isRom   = (dec.region == sap_pkg::RG_ROM);
  wire isSupFl = (dec.region == sap_pkg::RG_SUP_FL);
  wire isSecFl = (dec.region == sap_pkg::RG_SEC_FL);
  wire isFlash = (dec.region == sap_pkg::RG_APP_FL) || isSecFl ||
                 (dec.region == sap_pkg::RG_AUX_FL) || isSupFl;
  wire isSram  = (dec.region == sap_pkg::RG_SRAM_APP) ||
                 (dec.region == sap_pkg::RG_SRAM_SYS);

  wire unmapped   = (dec.region == sap_pkg::RG_NONE);
  wire fetchBad   = reqFetch && !dec.fetchOk;
  wire romBad     = isRom && reqFetch &&
                    !((reqMaster == sap_pkg::MST_SECOND) &&
                      (reqContext == sap_pkg::BOOT_CTX));
  wire secureBad  = (isSupFl || isSecFl) && !reqSecure;
  wire ulpWrite   = isFlash && reqWrite && (powerMode == sap_pkg::PM_ULP);
  wire lockedSup  = isSupFl && reqWrite && lifecycleSecure;
  wire romWrite   = isRom && reqWrite;
  wire sramOff    = isSram && !sramPowered[dec.sramBlock];
  wire mainCtxBad = inAppRun && (reqMaster == sap_pkg::MST_MAIN) &&
                    (reqContext != sap_pkg::APP_CTX);
  wire bootBad    = !inAppRun && (reqMaster != sap_pkg::MST_SECOND) &&
                    (reqMaster != sap_pkg::MST_DEBUG);

  wire denied = unmapped || !permOk || fetchBad || romBad || secureBad || ulpWrite ||
                lockedSup || romWrite || sramOff || mainCtxBad || bootBad;

  wire isPpb = (dec.region == sap_pkg::RG_PPB);

  // ****************************************************************
  // Access answer
  // ****************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      respValid  <= 1'b0;
      respError  <= 1'b0;
      respRegion <= sap_pkg::RG_NONE;
    end else begin
      respValid  <= reqValid;
      respError  <= reqValid && denied;
      respRegion <= reqValid ? dec.region : sap_pkg::RG_NONE;
    end
  end

  // Flash lines and cache sets follow the 128-bit word; rows the 512-byte row.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flashLineAddr <= 28'h000_0000;
      flashRowAddr  <= 23'h00_0000;
      flashRowWrite <= 1'b0;
      respCacheSel  <= 1'b0;
      respCacheSet  <= 7'h00;
      ppbLocal      <= 1'b0;
    end else begin
      flashLineAddr <= reqAddr[31:sap_pkg::FLASH_LINE_LSB];
      flashRowAddr  <= reqAddr[31:sap_pkg::FLASH_ROW_LSB];
      flashRowWrite <= reqValid && isFlash && reqWrite && !denied;
      respCacheSel  <= (reqMaster == sap_pkg::MST_SECOND);
      respCacheSet  <= reqAddr[sap_pkg::FLASH_LINE_LSB +: sap_pkg::CACHE_SET_W];
      ppbLocal      <= reqValid && isPpb && !denied;
    end
  end

  // ****************************************************************
  // Fault flag
  // ****************************************************************
  wire faultEvent = reqValid && denied;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      faultFlag <= 1'b0;
      faultAddr <= 32'h0000_0000;
    end else begin
      faultFlag <= faultEvent || (faultFlag && !faultClear);
      if (faultEvent) begin
        faultAddr <= reqAddr;
      end
    end
  end

  // ****************************************************************
  // SRAM power and retention
  // ****************************************************************
  // Hibernate drops every block; deep sleep keeps only retained ones.
  wire hib   = (powerMode == sap_pkg::PM_HIBERNATE);
  wire dsl   = (powerMode == sap_pkg::PM_DEEPSLEEP);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sramPowered  <= '0;
      sramRetained <= '0;
    end else begin
      sramPowered  <= hib ? '0 : dsl ? (sramPowerReq & sramRetainReq) : sramPowerReq;
      sramRetained <= hib ? '0 : (sramPowerReq & sramRetainReq);
    end
  end

  // ****************************************************************
  // System function requests
  // ****************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nmiSecond <= 1'b0;
    end else begin
      nmiSecond <= sysCallMain || sysCallSecond || sysCallDebug;
    end
  end

  // ****************************************************************
  // One-time fuse array
  // ****************************************************************
  // Reset models an unprogrammed part; a programmed bit only ever sets.
  logic [FUSE_BITS-1:0] fuses;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fuses <= '0;
    end else if (fuseProgValid) begin
      fuses[fuseProgIndex] <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fuseReadBit <= 1'b0;
    end else begin
      fuseReadBit <= fuses[fuseReadIndex];
    end
  end

  // ****************************************************************
  // Boot status outputs
  // ****************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bootPhase <= 5'b00001;
      safeState <= 1'b0;
    end else begin
      bootPhase <= next_boot;
      safeState <= (next_boot == BT_SAFE);
    end
  end

endmodule : system_address_protection

// ==== sim/bus_master_model.sv ====
// Behavioural bus master that issues one access at a time.
`timescale 1ns/1ps
module bus_master_model (
  // Clock
  input  wire logic        clk,
  // Request to the block
  output logic             reqValid,
  output logic [31:0]      reqAddr,
  output logic             reqWrite,
  output logic             reqFetch,
  output logic             reqPriv,
  output logic             reqSecure,
  output logic [2:0]       reqContext,
  output logic [2:0]       reqMaster
);
  initial begin
    reqValid = 1'b0;
    reqAddr = '0;
    {reqWrite, reqFetch, reqPriv, reqSecure, reqContext, reqMaster} = '0;
  end

  // Idle lines show the inverse.
  task automatic issue(input logic [31:0] a, input logic [3:0] wfps, input logic [2:0] c, m);
    @(posedge clk);
    #1;
    reqValid = 1'b1;
    reqAddr = a;
    {reqWrite, reqFetch, reqPriv, reqSecure} = wfps;
    reqContext = c;
    reqMaster = m;
    @(posedge clk);
    #1;
    reqValid = 1'b0;
    reqAddr = ~reqAddr;
    {reqWrite, reqFetch, reqPriv, reqSecure} = ~wfps;
    reqContext = ~c;
    reqMaster = ~m;
  endtask : issue
endmodule : bus_master_model

// ==== sim/sap_asserts.sv ====
// Concurrent checks on the ports of the address protection block.
`timescale 1ns/1ps
module sap_asserts (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Request and system state
  input  wire logic        reqValid,
  input  wire logic [31:0] reqAddr,
  input  wire logic        reqWrite,
  input  wire logic        reqFetch,
  input  wire logic        reqSecure,
  input  wire logic [2:0]  reqContext,
  input  wire logic [2:0]  reqMaster,
  input  sap_pkg::power_t  powerMode,
  input  wire logic        lifecycleSecure,
  input  wire logic        sysCallMain,
  input  wire logic        sysCallSecond,
  input  wire logic        sysCallDebug,
  // Answers
  input  logic             respValid,
  input  logic             respError,
  input  sap_pkg::region_t respRegion,
  input  logic [22:0]      flashRowAddr,
  input  logic             flashRowWrite,
  input  logic             faultFlag,
  input  logic [31:0]      faultAddr,
  input  logic             nmiSecond,
  input  logic [4:0]       bootPhase,
  input  logic             safeState
);
  logic inNomem, inPeri, inAppFl, inSupFl, inRom, romOwner;
  assign inNomem = reqAddr >= sap_pkg::NOMEM_BASE && reqAddr <= sap_pkg::NOMEM_LAST;
  assign inPeri = reqAddr >= sap_pkg::PERI_BASE && reqAddr <= sap_pkg::PERI_LAST;
  assign inAppFl = reqAddr >= sap_pkg::APP_FL_BASE && reqAddr <= sap_pkg::APP_FL_LAST;
  assign inSupFl = reqAddr >= sap_pkg::SUP_FL_BASE && reqAddr <= sap_pkg::SUP_FL_LAST;
  assign inRom = reqAddr <= sap_pkg::ROM_LAST;
  assign romOwner = reqMaster == sap_pkg::MST_SECOND && reqContext == sap_pkg::BOOT_CTX;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_answer_next: assert property (respValid == $past(reqValid))
    else $error("answer does not follow request by one cycle");
  chk_nomem_refused: assert property (reqValid && inNomem |=> respError)
    else $error("empty window access not refused");
  chk_peri_fetch: assert property (reqValid && reqFetch && inPeri |=> respError)
    else $error("fetch from peripheral space not refused");
  chk_ulp_write: assert property (reqValid && reqWrite && inAppFl &&
    powerMode == sap_pkg::PM_ULP |=> respError && !flashRowWrite)
    else $error("flash write granted in ultra low power");
  chk_sup_unsecured: assert property (reqValid && inSupFl && !reqSecure |=> respError)
    else $error("unsecured supervisory flash access granted");
  chk_sup_locked: assert property (reqValid && inSupFl && reqWrite &&
    lifecycleSecure |=> respError)
    else $error("supervisory flash write granted after lock");
  chk_rom_fetch: assert property (reqValid && reqFetch && inRom && !romOwner
    |=> respError)
    else $error("ROM fetch granted to wrong owner");
  chk_fault_capture: assert property (respValid && respError
    |-> faultFlag && faultAddr == $past(reqAddr))
    else $error("refused access not recorded");
  chk_row_addr: assert property (reqValid |=> flashRowAddr == $past(reqAddr[31:9]))
    else $error("flash row address wrong");
  chk_nmi_follow: assert property (nmiSecond ==
    $past(sysCallMain | sysCallSecond | sysCallDebug))
    else $error("secondary NMI does not follow request");
  chk_boot_phase: assert property ($onehot(bootPhase) && safeState == bootPhase[4])
    else $error("boot phase not one-hot");

  cover property (respValid && respError);
  cover property (flashRowWrite);
  cover property (nmiSecond);
  cover property (bootPhase == 5'h10);
endmodule : sap_asserts

bind system_address_protection sap_asserts u_chk (
  .clk, .arst_n, .reqValid, .reqAddr, .reqWrite, .reqFetch, .reqSecure, .reqContext,
  .reqMaster, .powerMode, .lifecycleSecure, .sysCallMain, .sysCallSecond, .sysCallDebug,
  .respValid, .respError, .respRegion, .flashRowAddr, .flashRowWrite, .faultFlag,
  .faultAddr, .nmiSecond, .bootPhase, .safeState
);

// ==== sim/tb_top.sv ====
// Self-checking bench for the address protection block.
`timescale 1ns/1ps
module tb_top;
  logic clk, arst_n, reqValid, reqWrite, reqFetch, reqPriv, reqSecure;
  logic [31:0] reqAddr, faultAddr;
  logic [2:0] reqContext, reqMaster, cfgContext, cfgMaster;
  logic respValid, respError, respCacheSel, flashRowWrite, ppbLocal, faultFlag;
  logic faultClear, cfgValid, lifecycleSecure, nmiSecond, fuseProgValid, fuseReadBit;
  logic sysCallMain, sysCallSecond, sysCallDebug, safeState;
  logic romBootDone, flashBootValid, flashBootDone, appImageValid;
  sap_pkg::region_t respRegion;
  sap_pkg::power_t powerMode;
  logic [6:0] respCacheSet;
  logic [27:0] flashLineAddr;
  logic [22:0] flashRowAddr;
  logic [5:0] cfgPerm;
  logic [8:0] sramPowerReq, sramRetainReq, sramPowered, sramRetained;
  logic [9:0] fuseProgIndex, fuseReadIndex;
  logic [4:0] bootPhase;
  int nErrors = 0;
  int checks = 0;

  system_address_protection dut_u (.*);
  bus_master_model bm (.*);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      nErrors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic acc(input logic [31:0] a, input logic [3:0] wfps, input logic [2:0] c, m,
                     input logic er, input logic [3:0] rg);
    bm.issue(a, wfps, c, m);
    chk(respValid, 1'b1);
    chk(respError, er);
    chk({respCacheSel, respCacheSet, respRegion}, {m == 3'h1, a[10:4], rg});
  endtask : acc

  task automatic t_decode;
    logic [31:0] ad [10] = '{32'h0000_0000, 32'h1000_0010, 32'h100D_0000, 32'h1400_7FFF,
      32'h1600_0000, 32'h2000_0000, 32'h4000_0000, 32'h9FFF_FFFF, 32'hE000_0000,
      32'hA000_0000};
    logic [3:0] rg [10] = '{4'h1, 4'h4, 4'h5, 4'h6, 4'h7, 4'h0, 4'h8, 4'h9, 4'hA, 4'h0};
    for (int i = 0; i < 10; i++) begin
      acc(ad[i], 4'b0011, 3'h0, 3'h1, rg[i] == 4'h0, rg[i]);
      chk(ppbLocal, rg[i] == 4'hA);
      chk(flashLineAddr, ad[i][31:4]);
    end
  endtask : t_decode

  task automatic t_fetch;
    acc(32'h4000_0100, 4'b0111, 3'h0, 3'h1, 1'b1, 4'h8);
    acc(32'h6000_0100, 4'b0111, 3'h0, 3'h1, 1'b0, 4'h9);
    acc(32'h0000_0100, 4'b0111, 3'h0, 3'h1, 1'b0, 4'h1);
    acc(32'h0000_0100, 4'b0111, 3'h1, 3'h1, 1'b1, 4'h1);
    acc(32'h0000_0100, 4'b0111, 3'h0, 3'h4, 1'b1, 4'h1);
    acc(32'h1600_0000, 4'b0010, 3'h0, 3'h1, 1'b1, 4'h7);
    acc(32'h1000_0000, 4'b0011, 3'h6, 3'h0, 1'b1, 4'h4);
  endtask : t_fetch

  task automatic t_flash;
    acc(32'h1000_0200, 4'b1011, 3'h0, 3'h1, 1'b0, 4'h4);
    chk(flashRowWrite, 1'b1);
    chk(flashRowAddr, 23'h08_0001);
    powerMode = sap_pkg::PM_ULP;
    acc(32'h1000_0200, 4'b1011, 3'h0, 3'h1, 1'b1, 4'h4);
    chk(flashRowWrite, 1'b0);
    acc(32'h1000_0200, 4'b0011, 3'h0, 3'h1, 1'b0, 4'h4);
    powerMode = sap_pkg::PM_LP;
    lifecycleSecure = 1'b1;
    acc(32'h1600_0000, 4'b1011, 3'h0, 3'h1, 1'b1, 4'h7);
    acc(32'h1600_0000, 4'b0011, 3'h0, 3'h1, 1'b0, 4'h7);
    lifecycleSecure = 1'b0;
  endtask : t_flash

  task automatic t_sram;
    acc(32'h0800_0000, 4'b0011, 3'h0, 3'h1, 1'b1, 4'h2);
    sramPowerReq = 9'h005;
    step(2);
    chk({sramPowered, sramRetained}, 18'h0_0A01);
    acc(32'h0800_0000, 4'b0011, 3'h0, 3'h1, 1'b0, 4'h2);
    acc(32'h0800_8000, 4'b0011, 3'h0, 3'h1, 1'b1, 4'h2);
    powerMode = sap_pkg::PM_DEEPSLEEP;
    step(2);
    chk(sramPowered, 9'h001);
    powerMode = sap_pkg::PM_HIBERNATE;
    step(2);
    chk({sramPowered, sramRetained}, 18'h0_0000);
    powerMode = sap_pkg::PM_LP;
  endtask : t_sram

  task automatic t_misc;
    acc(32'hA000_0004, 4'b0011, 3'h0, 3'h1, 1'b1, 4'h0);
    chk(faultFlag, 1'b1);
    chk(faultAddr, 32'hA000_0004);
    faultClear = 1'b1;
    step(1);
    faultClear = 1'b0;
    chk(faultFlag, 1'b0);
    for (int i = 0; i < 3; i++) begin
      {sysCallMain, sysCallSecond, sysCallDebug} = 3'b100 >> i;
      step(1);
      {sysCallMain, sysCallSecond, sysCallDebug} = 3'b000;
      chk(nmiSecond, 1'b1);
      step(1);
      chk(nmiSecond, 1'b0);
    end
    fuseProgIndex = 10'h3FF;
    fuseReadIndex = 10'h3FF;
    fuseProgValid = 1'b1;
    step(1);
    fuseProgValid = 1'b0;
    step(1);
    chk(fuseReadBit, 1'b1);
    fuseReadIndex = 10'h3FE;
    step(1);
    chk(fuseReadBit, 1'b0);
  endtask : t_misc

  task automatic t_app;
    romBootDone = 1'b1;
    flashBootValid = 1'b1;
    step(1);
    chk(bootPhase, 5'h04);
    romBootDone = 1'b0;
    flashBootDone = 1'b1;
    appImageValid = 1'b1;
    step(1);
    chk(bootPhase, 5'h08);
    flashBootDone = 1'b0;
    acc(32'h1000_0000, 4'b0000, 3'h6, 3'h0, 1'b0, 4'h4);
    acc(32'h1000_0000, 4'b1000, 3'h6, 3'h0, 1'b1, 4'h4);
    acc(32'h1000_0000, 4'b0000, 3'h5, 3'h0, 1'b1, 4'h4);
    cfgPerm = 6'h3F;
    cfgValid = 1'b1;
    step(1);
    cfgValid = 1'b0;
    acc(32'h1000_0000, 4'b1000, 3'h6, 3'h0, 1'b1, 4'h4);
  endtask : t_app

  task automatic t_safe;
    arst_n = 1'b0;
    step(2);
    chk(bootPhase, 5'h01);
    arst_n = 1'b1;
    step(1);
    chk(bootPhase, 5'h02);
    romBootDone = 1'b1;
    flashBootValid = 1'b0;
    step(1);
    chk(bootPhase, 5'h10);
    chk(safeState, 1'b1);
  endtask : t_safe

  task automatic endOfTest;
    if (nErrors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : endOfTest

  initial begin
    arst_n = 1'b0;
    {faultClear, cfgValid, lifecycleSecure, fuseProgValid} = 4'h0;
    {sysCallMain, sysCallSecond, sysCallDebug} = 3'b000;
    {romBootDone, flashBootValid, flashBootDone, appImageValid} = 4'h0;
    {cfgContext, cfgMaster, cfgPerm} = {3'h6, 3'h0, 6'h01};
    powerMode = sap_pkg::PM_LP;
    {sramPowerReq, sramRetainReq} = 18'h0_0001;
    {fuseProgIndex, fuseReadIndex} = 20'h0_0000;
    step(6);
    arst_n = 1'b1;
    step(1);
    chk(bootPhase, 5'h02);
    cfgValid = 1'b1;
    step(1);
    cfgValid = 1'b0;
    t_decode();
    t_fetch();
    t_flash();
    t_sram();
    t_misc();
    t_app();
    t_safe();
    endOfTest();
  end
endmodule : tb_top
